// file: core/ialc_top.sv
// alarm routing, data idle alarms and loopback control for the data interface
// Notes on behaviour
// RULE_01: send, test, hardware alarms routed by two bits
// RULE_02: receive data alarm has its own selector
// RULE_03: send idle alarm after programmed seconds
// RULE_04: receive idle alarm after programmed seconds
// RULE_05: satellite loopback returns receive into send
// RULE_06: terrestrial loopback returns send to receive
// RULE_07: framing level loopback returns send to receive
// RULE_08: twenty character code activates features, reported
// RULE_09: interface alarm three bits, high codes mute
// RULE_10: alarm changes ignored, logged or alerted
// RULE_11: idle timers restart on data, clear immediately
`timescale 1ns/1ps
module ialc_top
  import ialc_pkg::*;
#(
  parameter int DW = 8 // data path width
)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic sec_tick, // one-cycle pulse every second
  input wire logic ter_tx_valid, // terrestrial send input
  input wire logic [DW-1:0] ter_tx_data,
  input wire logic sat_rx_valid, // satellite receive input
  input wire logic [DW-1:0] sat_rx_data,
  output logic sat_tx_valid, // satellite send output
  output logic [DW-1:0] sat_tx_data,
  output logic ter_rx_valid, // terrestrial receive output
  output logic [DW-1:0] ter_rx_data,
  input wire logic ip_alarm_in, // general interface alarm source
  input wire logic hw_alarm_in, // hardware fault source
  input wire logic [IDLE_W-1:0] send_idle_sec,
  input wire logic [IDLE_W-1:0] rcv_idle_sec,
  input wire logic [1:0] send_mask,
  input wire logic [1:0] rcv_mask,
  input wire logic [1:0] test_mask,
  input wire logic [1:0] hw_mask,
  input wire logic [2:0] ip_mask,
  input wire logic sat_loop_en,
  input wire logic ter_wan_loop_en,
  input wire logic ter_hdlc_loop_en,
  input wire logic [2*ALM_N-1:0] event_mode, // two bits per alarm index
  input wire logic feat_load, // one-cycle pulse with the code
  input wire logic [FEAT_CHARS*CHAR_W-1:0] feat_code,
  output logic [FEAT_W-1:0] feat_active,
  output logic feat_reject,
  output logic alarm_a,
  output logic alarm_b,
  output logic mute_carrier,
  output logic test_active,
  output logic send_idle_alarm,
  output logic rcv_idle_alarm,
  output logic [ALM_N-1:0] log_event,
  output logic [ALM_N-1:0] alert_event
);
  ialc_idle_if send_if (); // idle timer at the send interface
  ialc_idle_if rcv_if (); // idle timer at the receive interface

  logic [ALM_N-1:0] alm_now; // current alarm levels
  logic [ALM_N-1:0] alm_prev_reg; // levels one cycle ago
  logic [ALM_N-1:0] log_next;
  logic [ALM_N-1:0] alert_next;
  logic [1:0] r_send;
  logic [1:0] r_rcv;
  logic [1:0] r_test;
  logic [1:0] r_hw;
  logic [1:0] r_ip;
  logic test_now;
  logic code_ok;

  // timers watch the raw interface activity, not the looped data
  assign send_if.activity = ter_tx_valid;
  assign send_if.tick = sec_tick;
  assign send_if.limit = ialc_clamp(send_idle_sec);
  assign rcv_if.activity = sat_rx_valid;
  assign rcv_if.tick = sec_tick;
  assign rcv_if.limit = ialc_clamp(rcv_idle_sec);

  ialc_idle_timer u_send_idle (
    .clock (clock),
    .resetn (resetn),
    .tif (send_if.timer)
  );

  ialc_idle_timer u_rcv_idle (
    .clock (clock),
    .resetn (resetn),
    .tif (rcv_if.timer)
  );

  // any loopback counts as a test in progress
  assign test_now = sat_loop_en | ter_wan_loop_en | ter_hdlc_loop_en;

  // alarm vector in index order
  always_comb begin
    alm_now = '0;
    alm_now[ALM_IP] = ip_alarm_in;
    alm_now[ALM_SEND] = send_if.alarm;
    alm_now[ALM_RCV] = rcv_if.alarm;
    alm_now[ALM_TEST] = test_now;
    alm_now[ALM_HW] = hw_alarm_in;
  end

  // per-source destinations
  assign r_send = ialc_route(send_mask, alm_now[ALM_SEND]); // see RULE_01
  assign r_test = ialc_route(test_mask, alm_now[ALM_TEST]); // see RULE_01
  assign r_hw = ialc_route(hw_mask, alm_now[ALM_HW]); // see RULE_01
  assign r_rcv = ialc_route(rcv_mask, alm_now[ALM_RCV]); // see RULE_02
  assign r_ip = ialc_route(ip_mask[MASK_B:MASK_A], alm_now[ALM_IP]); // see RULE_09

  // alarm outputs are the or of every routed source
  always_ff @(posedge clock) begin
    if (!resetn) begin
      alarm_a <= 1'b0;
      alarm_b <= 1'b0;
    end else begin
      alarm_a <= r_send[0] | r_rcv[0] | r_test[0] | r_hw[0] | r_ip[0]; // see RULE_01
      alarm_b <= r_send[1] | r_rcv[1] | r_test[1] | r_hw[1] | r_ip[1]; // see RULE_02
    end
  end

  // carrier mute follows the interface alarm only
  always_ff @(posedge clock) begin
    if (!resetn) begin
      mute_carrier <= 1'b0;
    end else begin
      mute_carrier <= ip_alarm_in & ip_mask[MASK_MUTE]; // see RULE_09
    end
  end

  // status levels shown outside
  always_ff @(posedge clock) begin
    if (!resetn) begin
      test_active <= 1'b0;
      send_idle_alarm <= 1'b0;
      rcv_idle_alarm <= 1'b0;
    end else begin
      test_active <= test_now;
      send_idle_alarm <= send_if.alarm; // see RULE_03
      rcv_idle_alarm <= rcv_if.alarm; // see RULE_04
    end
  end

  // satellite send path; loopback swaps in the receive stream
  always_ff @(posedge clock) begin
    if (!resetn) begin
      sat_tx_valid <= 1'b0;
      sat_tx_data <= '0;
    end else if (sat_loop_en) begin
      sat_tx_valid <= sat_rx_valid; // see RULE_05
      sat_tx_data <= sat_rx_data;
    end else begin
      sat_tx_valid <= ter_tx_valid;
      sat_tx_data <= ter_tx_data;
    end
  end

  // terrestrial receive path; either terrestrial loopback returns send data
  // both loops share one mux since each only needs the send stream back
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ter_rx_valid <= 1'b0;
      ter_rx_data <= '0;
    end else if (ter_wan_loop_en || ter_hdlc_loop_en) begin
      ter_rx_valid <= ter_tx_valid; // see RULE_06 see RULE_07
      ter_rx_data <= ter_tx_data;
    end else begin
      ter_rx_valid <= sat_rx_valid;
      ter_rx_data <= sat_rx_data;
    end
  end

  // change detection reference
  always_ff @(posedge clock) begin
    if (!resetn) begin
      alm_prev_reg <= '0;
    end else begin
      alm_prev_reg <= alm_now;
    end
  end

  // event decode per alarm; the unused code 3 logs without alert
  for (genvar i = 0; i < ALM_N; i++) begin : g_evt
    assign log_next[i] = (alm_now[i] != alm_prev_reg[i]) &&
                         (event_mode[2*i +: 2] != EVT_NONE); // see RULE_10
    assign alert_next[i] = (alm_now[i] != alm_prev_reg[i]) &&
                           (event_mode[2*i +: 2] == EVT_ALERT); // see RULE_10
  end

  // event pulses, one cycle per change
  always_ff @(posedge clock) begin
    if (!resetn) begin
      log_event <= '0;
      alert_event <= '0;
    end else begin
      log_event <= log_next;
      alert_event <= alert_next;
    end
  end

  // a code is accepted only if every character is a decimal digit
  always_comb begin
    code_ok = 1'b1;
    for (int c = 0; c < FEAT_CHARS; c++) begin
      if ((feat_code[c*CHAR_W +: CHAR_W] < CHAR_ZERO) ||
          (feat_code[c*CHAR_W +: CHAR_W] > CHAR_NINE)) begin
        code_ok = 1'b0;
      end
    end
  end

  // active features come from the last digit; a bad code keeps the old set
  always_ff @(posedge clock) begin
    if (!resetn) begin
      feat_active <= '0;
      feat_reject <= 1'b0;
    end else begin
      feat_reject <= feat_load & !code_ok;
      if (feat_load && code_ok) begin
        feat_active <= feat_code[FEAT_W-1:0]; // see RULE_08
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_hw_both;
    (hw_alarm_in && hw_mask == ROUTE_BOTH) |=> alarm_a && alarm_b;
  endproperty
  a_hw_both: assert property (p_hw_both) else $error("hardware alarm not on both outputs"); // see RULE_01

  property p_route_none;
    (send_mask == ROUTE_NONE && rcv_mask == ROUTE_NONE && test_mask == ROUTE_NONE &&
     hw_mask == ROUTE_NONE && ip_mask[MASK_B:MASK_A] == ROUTE_NONE) |=> !alarm_a && !alarm_b;
  endproperty
  a_route_none: assert property (p_route_none) else $error("alarm output with no route"); // see RULE_02

  property p_mute;
    (ip_alarm_in && ip_mask[MASK_MUTE]) |=> mute_carrier ##1
      (mute_carrier == ($past(ip_alarm_in) && $past(ip_mask[MASK_MUTE])));
  endproperty
  a_mute: assert property (p_mute) else $error("carrier not muted"); // see RULE_09

  property p_no_mute;
    !ip_alarm_in |=> !mute_carrier;
  endproperty
  a_no_mute: assert property (p_no_mute) else $error("carrier muted without alarm"); // see RULE_09

  property p_sat_loop;
    sat_loop_en |=> (sat_tx_data == $past(sat_rx_data)) && (sat_tx_valid == $past(sat_rx_valid));
  endproperty
  a_sat_loop: assert property (p_sat_loop) else $error("satellite loopback data wrong"); // see RULE_05

  property p_sat_norm;
    !sat_loop_en |=> (sat_tx_data == $past(ter_tx_data)) && (sat_tx_valid == $past(ter_tx_valid));
  endproperty
  a_sat_norm: assert property (p_sat_norm) else $error("send path wrong"); // see RULE_05

  property p_ter_loop;
    ter_wan_loop_en |=> (ter_rx_data == $past(ter_tx_data)) && (ter_rx_valid == $past(ter_tx_valid));
  endproperty
  a_ter_loop: assert property (p_ter_loop) else $error("terrestrial loopback wrong"); // see RULE_06

  property p_hdlc_loop;
    (ter_hdlc_loop_en && !ter_wan_loop_en) |=> ter_rx_data == $past(ter_tx_data);
  endproperty
  a_hdlc_loop: assert property (p_hdlc_loop) else $error("framing loopback wrong"); // see RULE_07

  property p_evt_alert;
    (alm_now[ALM_HW] != alm_prev_reg[ALM_HW] && event_mode[2*ALM_HW +: 2] == EVT_ALERT)
      |=> alert_event[ALM_HW] && log_event[ALM_HW] ##1 !alert_event[ALM_HW] || $past(alert_next[ALM_HW]);
  endproperty
  a_evt_alert: assert property (p_evt_alert) else $error("alert missing on change"); // see RULE_10

  property p_evt_none;
    (event_mode[2*ALM_SEND +: 2] == EVT_NONE) |=> !log_event[ALM_SEND] && !alert_event[ALM_SEND];
  endproperty
  a_evt_none: assert property (p_evt_none) else $error("event logged while ignored"); // see RULE_10

  property p_feat;
    feat_load && code_ok |=> feat_active == $past(feat_code[FEAT_W-1:0]) && !feat_reject;
  endproperty
  a_feat: assert property (p_feat) else $error("feature set not taken"); // see RULE_08

  c_sat_loop: cover property (sat_loop_en ##1 sat_tx_valid);
  c_send_idle: cover property ($rose(send_idle_alarm));
  c_rcv_idle: cover property ($rose(rcv_idle_alarm) ##[1:20] $fell(rcv_idle_alarm));
  c_alert: cover property (|alert_event);
endmodule

// file: core/ialc_pkg.sv
// shared constants and decode helpers for the interface alarm and loopback block
package ialc_pkg;
  // idle timer limits, in whole seconds
  localparam int IDLE_W = 14;
  localparam logic [IDLE_W-1:0] IDLE_SEC_MAX = 14'h270f; // 9999 s, largest setting
  localparam logic [IDLE_W-1:0] IDLE_OFF = 14'h0000; // zero disables the idle alarm
  localparam logic [IDLE_W-1:0] IDLE_STEP = 14'h0001;
  // alarm selector bit positions
  localparam int MASK_A = 0;
  localparam int MASK_B = 1;
  localparam int MASK_MUTE = 2;
  localparam logic [1:0] ROUTE_NONE = 2'h0;
  localparam logic [1:0] ROUTE_BOTH = 2'h3;
  // per-alarm event handling codes
  localparam logic [1:0] EVT_NONE = 2'h0;
  localparam logic [1:0] EVT_LOG = 2'h1;
  localparam logic [1:0] EVT_ALERT = 2'h2;
  // alarm indices in the status vector
  localparam int ALM_N = 5;
  localparam int ALM_IP = 0;
  localparam int ALM_SEND = 1;
  localparam int ALM_RCV = 2;
  localparam int ALM_TEST = 3;
  localparam int ALM_HW = 4;
  // feature activation code
  localparam int FEAT_CHARS = 20;
  localparam int CHAR_W = 8;
  localparam int FEAT_W = 4;
  localparam logic [CHAR_W-1:0] CHAR_ZERO = 8'h30;
  localparam logic [CHAR_W-1:0] CHAR_NINE = 8'h39;

  // two-bit destination decode: returns {to_b, to_a}
  function automatic logic [1:0] ialc_route(input logic [1:0] sel, input logic alm);
    ialc_route = {sel[MASK_B] & alm, sel[MASK_A] & alm};
  endfunction

  // clamp an idle setting to the documented range
  function automatic logic [IDLE_W-1:0] ialc_clamp(input logic [IDLE_W-1:0] sec);
    ialc_clamp = (sec > IDLE_SEC_MAX) ? IDLE_SEC_MAX : sec;
  endfunction
endpackage

// file: core/ialc_idle_if.sv
// interface between the top block and one data idle timer
`timescale 1ns/1ps
interface ialc_idle_if;
  import ialc_pkg::*;
  logic activity; // data seen this cycle
  logic tick; // one-second tick
  logic [IDLE_W-1:0] limit; // idle time in seconds, zero is off
  logic alarm; // idle alarm level
  modport timer (input activity, input tick, input limit, output alarm);
  modport user (output activity, output tick, output limit, input alarm);
endinterface

// file: core/ialc_idle_timer.sv
// data idle timer: counts seconds without activity and raises an alarm
`timescale 1ns/1ps
module ialc_idle_timer
  import ialc_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  ialc_idle_if.timer tif
);
  logic [IDLE_W-1:0] count_reg; // seconds since last activity
  logic [IDLE_W-1:0] count_next;
  logic alarm_reg;
  logic alarm_next;

  // next count: activity restarts, a tick advances until the limit
  always_comb begin
    count_next = count_reg;
    if (tif.activity) begin
      count_next = IDLE_OFF; // see RULE_11
    end else if (tif.tick && (count_reg < tif.limit)) begin
      count_next = count_reg + IDLE_STEP; // stops at limit so it cannot wrap
    end
    // activity in the same cycle always clears, even on the tick
    alarm_next = (tif.limit != IDLE_OFF) && !tif.activity && (count_next >= tif.limit);
  end

  // second counter
  always_ff @(posedge clock) begin
    if (!resetn) begin
      count_reg <= IDLE_OFF;
    end else begin
      count_reg <= count_next; // see RULE_11
    end
  end

  // alarm level; lowering the limit below the count raises it at once
  always_ff @(posedge clock) begin
    if (!resetn) begin
      alarm_reg <= 1'b0;
    end else begin
      alarm_reg <= alarm_next; // see RULE_03 see RULE_04
    end
  end

  assign tif.alarm = alarm_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_idle_clear;
    tif.activity |=> !tif.alarm;
  endproperty
  a_idle_clear: assert property (p_idle_clear) else $error("idle alarm not cleared by data"); // see RULE_11

  property p_idle_off;
    (tif.limit == IDLE_OFF) |=> !tif.alarm;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("idle alarm raised while disabled"); // see RULE_03

  property p_idle_rise;
    $rose(tif.alarm) |-> ($past(count_next) >= $past(tif.limit)) && !$past(tif.activity);
  endproperty
  a_idle_rise: assert property (p_idle_rise) else $error("idle alarm raised early"); // see RULE_04
endmodule

// file: sim/ialc_sat_model.sv
// far-side model: satellite receive source and satellite send sink
`timescale 1ns/1ps
module ialc_sat_model #(
  parameter int DW = 8 // data path width
)
(
  input wire logic clock,
  input wire logic en, // stream receive data while high
  output logic sat_rx_valid,
  output logic [DW-1:0] sat_rx_data,
  input wire logic sat_tx_valid,
  input wire logic [DW-1:0] sat_tx_data,
  output logic [15:0] tx_beats // send beats seen
);
  logic en_q = 1'b0; // enable sampled on the rising edge so bench writes never race

  initial begin
    sat_rx_valid = 1'b0;
    sat_rx_data = 8'h5a;
    tx_beats = 16'h0000;
  end
  // enable copy; the bench changes en on the falling edge, the same edge the beats use
  always @(posedge clock) begin
    en_q <= en;
  end
  // new beat after each falling edge; idle data keeps toggling so a stale copy never matches
  always @(negedge clock) begin
    sat_rx_valid <= en_q;
    sat_rx_data <= en_q ? sat_rx_data + 8'h01 : ~sat_rx_data;
  end
  // count beats the modem sends towards the satellite
  always @(posedge clock) begin
    if (sat_tx_valid === 1'b1) begin
      tx_beats <= tx_beats + 16'h0001;
    end
  end
endmodule

// file: sim/ialc_top_tb.sv
// self-checking bench for the alarm routing, idle alarm and loopback block
`timescale 1ns/1ps
module ialc_top_tb;
  import ialc_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic sec_tick = 1'b1; // tick every cycle keeps idle times short
  logic ter_tx_valid = 1'b1;
  logic [7:0] ter_tx_data = 8'h00;
  logic ip_alarm_in = 1'b0;
  logic hw_alarm_in = 1'b0;
  logic [IDLE_W-1:0] send_idle_sec = IDLE_OFF;
  logic [IDLE_W-1:0] rcv_idle_sec = IDLE_OFF;
  logic [1:0] send_mask = 2'h0, rcv_mask = 2'h0, test_mask = 2'h0, hw_mask = 2'h0;
  logic [2:0] ip_mask = 3'h0;
  logic sat_loop_en = 1'b0, ter_wan_loop_en = 1'b0, ter_hdlc_loop_en = 1'b0;
  logic [2*ALM_N-1:0] event_mode = 10'h000;
  logic feat_load = 1'b0;
  logic [FEAT_CHARS*CHAR_W-1:0] feat_code = {FEAT_CHARS{CHAR_ZERO}};
  logic rx_en = 1'b0; // far side streams receive data
  logic sat_rx_valid, sat_tx_valid, ter_rx_valid, feat_reject;
  logic [7:0] sat_rx_data, sat_tx_data, ter_rx_data;
  logic [FEAT_W-1:0] feat_active;
  logic alarm_a, alarm_b, mute_carrier, test_active, send_idle_alarm, rcv_idle_alarm;
  logic [ALM_N-1:0] log_event, alert_event;
  logic [15:0] tx_beats;
  int errors = 0;
  int checked = 0;

  // 20 MHz clock
  always #25 clock = ~clock;

  ialc_top #(.DW(8)) ialc_top_inst (.clock(clock), .resetn(resetn), .sec_tick(sec_tick),
    .ter_tx_valid(ter_tx_valid), .ter_tx_data(ter_tx_data), .sat_rx_valid(sat_rx_valid),
    .sat_rx_data(sat_rx_data), .sat_tx_valid(sat_tx_valid), .sat_tx_data(sat_tx_data),
    .ter_rx_valid(ter_rx_valid), .ter_rx_data(ter_rx_data), .ip_alarm_in(ip_alarm_in),
    .hw_alarm_in(hw_alarm_in), .send_idle_sec(send_idle_sec), .rcv_idle_sec(rcv_idle_sec),
    .send_mask(send_mask), .rcv_mask(rcv_mask), .test_mask(test_mask), .hw_mask(hw_mask),
    .ip_mask(ip_mask), .sat_loop_en(sat_loop_en), .ter_wan_loop_en(ter_wan_loop_en),
    .ter_hdlc_loop_en(ter_hdlc_loop_en), .event_mode(event_mode), .feat_load(feat_load),
    .feat_code(feat_code), .feat_active(feat_active), .feat_reject(feat_reject),
    .alarm_a(alarm_a), .alarm_b(alarm_b), .mute_carrier(mute_carrier),
    .test_active(test_active), .send_idle_alarm(send_idle_alarm),
    .rcv_idle_alarm(rcv_idle_alarm), .log_event(log_event), .alert_event(alert_event));

  ialc_sat_model #(.DW(8)) ialc_sat_model_inst (.clock(clock), .en(rx_en),
    .sat_rx_valid(sat_rx_valid), .sat_rx_data(sat_rx_data), .sat_tx_valid(sat_tx_valid),
    .sat_tx_data(sat_tx_data), .tx_beats(tx_beats));

  // compare one observed value against the expected one
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // wait n falling edges; inputs change and outputs are read there
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  // verdict and end of run
  task automatic finish_test();
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard: the sequence needs about 10,100 cycles, mostly the long receive idle wait
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    finish_test();
  end

  initial begin
    cyc(5);
    chk({alarm_a, alarm_b, mute_carrier, test_active, feat_active}, 16'h0000);
    cyc(1);
    resetn = 1'b1;
    // hardware source through every destination code
    hw_alarm_in = 1'b1;
    for (int m = 0; m < 4; m++) begin
      hw_mask = m[1:0];
      cyc(1);
      chk({alarm_b, alarm_a}, m[1:0]);
    end
    hw_mask = 2'h0;
    // interface alarm: destinations plus carrier mute for the high codes
    ip_alarm_in = 1'b1;
    for (int m = 0; m < 8; m++) begin
      ip_mask = m[2:0];
      cyc(1);
      chk({mute_carrier, alarm_b, alarm_a}, m[2:0]);
    end
    ip_alarm_in = 1'b0;
    hw_alarm_in = 1'b0;
    ip_mask = 3'h0;
    // terrestrial loopback with test-active routing
    ter_wan_loop_en = 1'b1;
    ter_tx_data = 8'ha5;
    for (int m = 0; m < 4; m++) begin
      test_mask = m[1:0];
      cyc(2);
      chk({test_active, alarm_b, alarm_a}, {1'b1, m[1:0]});
    end
    chk({ter_rx_valid, ter_rx_data}, 16'h01a5);
    chk({sat_tx_valid, sat_tx_data}, 16'h01a5);
    test_mask = 2'h0;
    ter_wan_loop_en = 1'b0;
    ter_hdlc_loop_en = 1'b1;
    ter_tx_data = 8'h3c;
    cyc(1);
    chk({ter_rx_valid, ter_rx_data}, 16'h013c);
    ter_hdlc_loop_en = 1'b0;
    rx_en = 1'b1;
    cyc(2);
    chk({ter_rx_valid, ter_rx_data}, {sat_rx_valid, sat_rx_data});
    // satellite loopback: send output follows receive input, back to back
    sat_loop_en = 1'b1;
    cyc(1);
    repeat (3) begin
      cyc(1);
      chk({sat_tx_valid, sat_tx_data}, {sat_rx_valid, sat_rx_data});
    end
    sat_loop_en = 1'b0;
    cyc(2);
    chk(test_active, 1'b0);
    // send idle: zero setting never alarms, three seconds does
    ter_tx_valid = 1'b0;
    cyc(20);
    chk(send_idle_alarm, 1'b0);
    send_idle_sec = 14'h0003;
    send_mask = 2'h1;
    cyc(2);
    chk(send_idle_alarm, 1'b0);
    cyc(5);
    chk({send_idle_alarm, alarm_a}, 2'h3);
    ter_tx_valid = 1'b1;
    cyc(1);
    ter_tx_valid = 1'b0;
    cyc(2);
    chk({send_idle_alarm, alarm_a}, 2'h0);
    send_idle_sec = IDLE_OFF;
    // receive idle: oversize setting is held at the maximum, then two seconds
    rcv_idle_sec = 14'h3fff;
    rx_en = 1'b0;
    cyc(9990);
    chk(rcv_idle_alarm, 1'b0);
    // just past 9999 seconds the clamped setting has expired
    cyc(20);
    chk(rcv_idle_alarm, 1'b1);
    rcv_idle_sec = 14'h0002;
    rcv_mask = 2'h2;
    cyc(6);
    chk({rcv_idle_alarm, alarm_b, alarm_a}, 3'h6);
    // event handling: hardware logs and alerts, interface alarm logs only
    event_mode = 10'h201;
    hw_alarm_in = 1'b1;
    ip_alarm_in = 1'b1;
    cyc(1);
    chk({alert_event, log_event}, 16'h0211);
    cyc(1);
    chk({alert_event, log_event}, 16'h0000);
    event_mode = 10'h000;
    hw_alarm_in = 1'b0;
    cyc(1);
    chk({alert_event, log_event}, 16'h0000);
    // code 3 is taken as log without alert
    event_mode = 10'h300;
    hw_alarm_in = 1'b1;
    cyc(1);
    chk({alert_event, log_event}, 16'h0010);
    event_mode = 10'h000;
    hw_alarm_in = 1'b0;
    // feature code: all digits accepted, a letter refused back to back
    feat_code[7:0] = 8'h35;
    feat_load = 1'b1;
    cyc(1);
    chk({feat_reject, feat_active}, 16'h0005);
    feat_code[15:8] = 8'h41;
    cyc(1);
    feat_load = 1'b0;
    chk({feat_reject, feat_active}, 16'h0015);
    cyc(1);
    chk({feat_reject, feat_active}, 16'h0005);
    // reset in mid-run: outputs drop, then the receive timer starts afresh
    resetn = 1'b0;
    cyc(2);
    chk({feat_active, alarm_a, alarm_b, rcv_idle_alarm, log_event}, 16'h0000);
    resetn = 1'b1;
    cyc(1);
    chk(rcv_idle_alarm, 1'b0);
    cyc(3);
    chk({rcv_idle_alarm, alarm_b}, 2'h3);
    // receive data returns and clears the alarm
    rx_en = 1'b1;
    cyc(4);
    chk({rcv_idle_alarm, alarm_b}, 2'h0);
    chk(tx_beats > 16'h0000, 1'b1);
    finish_test();
  end
endmodule
